// ==== inc/lps_pkg.sv ====
// Constants and types shared by the low-power stop clock control block
package lps_pkg;

   // Register byte offsets on the APB word map
   localparam logic [7:0] LPS_OFF_CTRL = 8'h00;
   localparam logic [7:0] LPS_OFF_STATUS = 8'h04;
   localparam logic [7:0] LPS_OFF_MASK = 8'h08;
   localparam logic [7:0] LPS_OFF_STATE = 8'h0C;
   localparam logic [7:0] LPS_OFF_COUNT = 8'h10;

   // Control register layout, bit 0 is the last field
   typedef struct packed {
      logic watchdog_pseudo_stop_enable;   // Bit 6
      logic rti_pseudo_stop_enable;        // Bit 5
      logic pseudo_stop_selection;         // Bit 4
      logic pll_select_bit;                // Bit 3
      logic self_clock_interrupt_enable;   // Bit 2
      logic self_clock_mode_enable;        // Bit 1
      logic clock_monitor_enable;          // Bit 0
   } lps_ctrl_t;
   localparam int LPS_CTRL_W = 7;
   localparam lps_ctrl_t LPS_CTRL_RESET = 7'h00;

   // Sticky status bits, the mask register shares this layout
   localparam int LPS_STAT_W = 3;
   localparam int LPS_STAT_SCM_FLAG = 0;   // self_clock_interrupt_flag
   localparam int LPS_STAT_QC_OK = 1;      // Quality check passed
   localparam int LPS_STAT_WAKE = 2;       // Left stop or wait
   localparam logic [2:0] LPS_STAT_RESET = 3'h0;
   localparam logic [2:0] LPS_MASK_RESET = 3'h0;

   // State register bit positions
   localparam int LPS_ST_STOP = 0;
   localparam int LPS_ST_WAIT = 1;
   localparam int LPS_ST_SCM = 2;
   localparam int LPS_ST_ON_PLL = 3;
   localparam int LPS_ST_QC = 4;
   localparam int LPS_ST_ALT_VEC = 5;

   // Oscillator cycles a recovered clock must run before it counts as good
   localparam int LPS_QC_OSC_CYCLES = 4096;

   // Clock and power enables sent to the rest of the chip
   typedef struct packed {
      logic osc;       // Oscillator running
      logic pll;       // PLL powered
      logic core;      // Core clock
      logic sys;       // Remaining system clocks
      logic periodic_interrupt_timer;       // periodic_interrupt_timer clock
      logic wdog;      // watchdog_counter clock
      logic voltage_regulator_lp;   // Low-power request to the voltage_regulator
   } lps_gate_t;
   localparam lps_gate_t LPS_GATE_RESET = 7'h7E;

   // Gating sequence states
   typedef enum logic [2:0] {
      LPS_RUN,
      LPS_DROP_PLL_SELECT_BIT,
      LPS_PLL_OFF,
      LPS_CORE_OFF,
      LPS_STOPPED
   } lps_state_t;

endpackage

// ==== hw/lps_stop_ctrl.sv ====
// Low-power stop, pseudo-stop and self-clock control with APB registers
// Notes on behaviour
// (R1) Wait clock loss, all enabled: self-clock, wake
// (R2) After wake run on PLL, keep checking
// (R3) Stop halts clocks except selected survivors
// (R4) Oscillator off in stop unless pseudo-stop
// (R5) Counters and dividers freeze, never clear
// (R6) Timer and watchdog run in pseudo-stop
// (R7) Stop also requests regulator power saving
// (R8) Clear PLL select, then PLL, core, system
// (R9) Pseudo-stop from self-clock keeps PLL, regulator
// (R10) Full stop aborts check, restarts on exit
// (R11) External reset restores defaults, run mode
// (R12) Loss without self-clock gives monitor reset
// (R13) Loss with interrupt enabled wakes in self-clock
// (R14) Interrupt disabled: flag set, stay asleep
// (R15) Other wake runs on oscillator, select cleared; with self-clock mode still set it resumes on the PLL
// (R16) Clock good after fixed oscillator cycle count
// (R17) Single-cycle request; stopped only after sequence
`timescale 1ns/1ps
`default_nettype none

module lps_stop_ctrl #(
   parameter int QC_CYCLES = lps_pkg::LPS_QC_OSC_CYCLES,
   parameter int CNT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_req,
   input wire logic wait_req,
   input wire logic clock_fail,
   input wire logic osc_tick,
   input wire logic wake_irq,
   output lps_pkg::lps_gate_t gate,
   output logic stop_active,
   output logic wait_active,
   output logic self_clock_mode,
   output logic sys_on_pll,
   output logic qc_busy,
   output logic clock_monitor_fail_reset,
   output logic alt_reset_vector,
   output logic irq
);

   localparam int QC_W = $clog2(QC_CYCLES);

   // Bus handshake strobes
   logic wr_en;
   logic rd_en;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;

   // Control state
   lps_pkg::lps_ctrl_t ctrl;
   lps_pkg::lps_ctrl_t next_ctrl;
   lps_pkg::lps_state_t state;
   lps_pkg::lps_state_t next_state;
   logic is_wait;               // Current sleep came from a wait request
   logic next_is_wait;
   logic next_scm;
   logic next_qc_busy;
   logic [QC_W-1:0] qc_cnt;     // Oscillator cycles seen since recovery
   logic [QC_W-1:0] next_qc_cnt;
   lps_pkg::lps_gate_t next_gate;
   logic next_stop_active;
   logic next_wait_active;
   logic next_sys_on_pll;
   logic next_cm_reset;
   logic next_alt_vec;
   logic fail_q;                // Last cycle's clock monitor level
   logic [CNT_W-1:0] div_cnt;   // System clock divider
   logic [CNT_W-1:0] rti_cnt;   // periodic_interrupt_timer count
   logic [CNT_W-1:0] wdog_cnt;  // watchdog_counter count
   logic [CNT_W-1:0] next_div_cnt;
   logic [CNT_W-1:0] next_rti_cnt;
   logic [CNT_W-1:0] next_wdog_cnt;

   // Decoded conditions
   logic asleep;       // Wait or pseudo-stop, monitor still alive
   logic full_stop;    // Oscillator off, nothing to monitor
   logic loss_evt;     // New clock failure seen by the monitor
   logic qc_done;
   logic [lps_pkg::LPS_STAT_W-1:0] evt;

   // Interrupt state
   logic [lps_pkg::LPS_STAT_W-1:0] status;
   logic [lps_pkg::LPS_STAT_W-1:0] mask;
   logic [lps_pkg::LPS_STAT_W-1:0] next_status;
   logic [lps_pkg::LPS_STAT_W-1:0] next_mask;
   logic [lps_pkg::LPS_STAT_W-1:0] rd_clr;
   logic next_irq;

   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & pready & ~pwrite;

   // APB slave: decode in setup, answer with zero wait in access
   always_comb begin
      next_pready = psel & ~penable;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (psel && !penable) begin
         case (paddr)
            lps_pkg::LPS_OFF_CTRL: begin
               next_prdata = 32'(ctrl);
            end
            lps_pkg::LPS_OFF_STATUS: begin
               next_prdata = 32'(status);
            end
            lps_pkg::LPS_OFF_MASK: begin
               next_prdata = 32'(mask);
            end
            lps_pkg::LPS_OFF_STATE: begin
               next_prdata[lps_pkg::LPS_ST_STOP] = stop_active;
               next_prdata[lps_pkg::LPS_ST_WAIT] = wait_active;
               next_prdata[lps_pkg::LPS_ST_SCM] = self_clock_mode;
               next_prdata[lps_pkg::LPS_ST_ON_PLL] = sys_on_pll;
               next_prdata[lps_pkg::LPS_ST_QC] = qc_busy;
               next_prdata[lps_pkg::LPS_ST_ALT_VEC] = alt_reset_vector;
            end
            lps_pkg::LPS_OFF_COUNT: begin
               next_prdata = 32'({wdog_cnt, rti_cnt, div_cnt});
            end
            default: begin
               // Unmapped word answers with an error and zero data
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   assign asleep = (state == lps_pkg::LPS_STOPPED) && (is_wait || ctrl.pseudo_stop_selection);
   assign full_stop = (state == lps_pkg::LPS_STOPPED) && !is_wait
                      && !ctrl.pseudo_stop_selection;
   // Monitor cannot see a loss while the oscillator itself is off
   assign loss_evt = ctrl.clock_monitor_enable && clock_fail && !fail_q && !full_stop;
   assign qc_done = qc_busy && !full_stop && !clock_fail && osc_tick
                    && (qc_cnt == QC_W'(QC_CYCLES - 1));

   // Mode sequencer, self-clock tracking, quality check and counters
   always_comb begin
      next_ctrl = ctrl;
      next_state = state;
      next_is_wait = is_wait;
      next_scm = self_clock_mode;
      next_qc_busy = qc_busy;
      next_qc_cnt = qc_cnt;
      next_cm_reset = 1'b0;
      next_alt_vec = alt_reset_vector;
      evt = '0;
      if (wr_en && paddr == lps_pkg::LPS_OFF_CTRL) begin
         next_ctrl = lps_pkg::lps_ctrl_t'(pwdata[lps_pkg::LPS_CTRL_W-1:0]);
      end
      // Quality checker: any failure restarts the window
      if (qc_busy) begin
         if (full_stop) begin
            // Aborted check holds at zero so exit starts a whole window
            next_qc_cnt = '0; // R10
         end else if (clock_fail) begin
            next_qc_cnt = '0; // R2
         end else if (qc_done) begin
            // Oscillator good again, leave self-clock mode
            next_qc_busy = 1'b0; // R16
            next_scm = 1'b0; // R16
            next_qc_cnt = '0;
            evt[lps_pkg::LPS_STAT_QC_OK] = 1'b1;
         end else if (osc_tick) begin
            next_qc_cnt = qc_cnt + QC_W'(1); // R16
         end
      end
      case (state)
         lps_pkg::LPS_RUN: begin
            // A new request is only taken from run mode
            if (stop_req || wait_req) begin
               next_state = lps_pkg::LPS_DROP_PLL_SELECT_BIT; // R17
               next_is_wait = wait_req && !stop_req;
            end
         end
         lps_pkg::LPS_DROP_PLL_SELECT_BIT: begin
            next_state = lps_pkg::LPS_PLL_OFF; // R8
         end
         lps_pkg::LPS_PLL_OFF: begin
            next_state = lps_pkg::LPS_CORE_OFF; // R8
         end
         lps_pkg::LPS_CORE_OFF: begin
            next_state = lps_pkg::LPS_STOPPED; // R8
         end
         lps_pkg::LPS_STOPPED: begin
            // Any other wake source resumes on the oscillator clock, or on the PLL if self-clock mode is still set
            if (wake_irq) begin
               next_state = lps_pkg::LPS_RUN; // R15
            end
         end
         default: begin
            next_state = lps_pkg::LPS_RUN;
         end
      endcase
      // Clock loss outranks the sequence and ordinary wake-ups
      if (loss_evt) begin
         if (!ctrl.self_clock_mode_enable) begin
            // Monitor reset: defaults back, alternate vector fetched
            next_cm_reset = 1'b1; // R12
            next_alt_vec = 1'b1; // R12
            next_ctrl = lps_pkg::LPS_CTRL_RESET; // R12
            next_state = lps_pkg::LPS_RUN; // R12
            next_is_wait = 1'b0;
            next_scm = 1'b0;
            next_qc_busy = 1'b0;
            next_qc_cnt = '0;
         end else begin
            // Flag is set even when it may not wake the device
            evt[lps_pkg::LPS_STAT_SCM_FLAG] = 1'b1; // R14
            next_scm = 1'b1; // R1 R13
            next_qc_busy = 1'b1; // R1 R13
            next_qc_cnt = '0;
            if (asleep && ctrl.self_clock_interrupt_enable) begin
               next_state = lps_pkg::LPS_RUN; // R1 R13
            end else if (asleep) begin
               next_state = lps_pkg::LPS_STOPPED; // R14
            end
         end
      end
      if (state == lps_pkg::LPS_STOPPED && next_state == lps_pkg::LPS_RUN) begin
         evt[lps_pkg::LPS_STAT_WAKE] = 1'b1;
         next_is_wait = 1'b0;
      end
      // PLL select stays cleared for the whole sequence and sleep
      if (next_state != lps_pkg::LPS_RUN) begin
         next_ctrl.pll_select_bit = 1'b0; // R8 R15
      end
   end

   // Clock and power enables follow the next state
   always_comb begin
      next_gate.core = (next_state == lps_pkg::LPS_RUN)
                       || (next_state == lps_pkg::LPS_DROP_PLL_SELECT_BIT)
                       || (next_state == lps_pkg::LPS_PLL_OFF); // R8
      next_gate.sys = (next_state != lps_pkg::LPS_STOPPED); // R3 R8
      // Self-clock needs the PLL while asleep; full stop drops it
      next_gate.pll = (next_state == lps_pkg::LPS_RUN)
                      || (next_state == lps_pkg::LPS_DROP_PLL_SELECT_BIT)
                      || (next_scm && (next_is_wait || next_ctrl.pseudo_stop_selection)); // R1 R9
      next_gate.osc = !(next_state == lps_pkg::LPS_STOPPED && !next_is_wait
                        && !next_ctrl.pseudo_stop_selection); // R4
      next_gate.periodic_interrupt_timer = (next_state != lps_pkg::LPS_STOPPED) || next_is_wait
                      || (next_ctrl.pseudo_stop_selection
                          && next_ctrl.rti_pseudo_stop_enable); // R3 R6
      next_gate.wdog = (next_state != lps_pkg::LPS_STOPPED) || next_is_wait
                       || (next_ctrl.pseudo_stop_selection
                           && next_ctrl.watchdog_pseudo_stop_enable); // R3 R6
      // Wait never lowers the regulator; self-clock pseudo-stop keeps it up
      next_gate.voltage_regulator_lp = (next_state == lps_pkg::LPS_STOPPED) && !next_is_wait
                          && !(next_ctrl.pseudo_stop_selection && next_scm); // R7 R9
      next_stop_active = (next_state == lps_pkg::LPS_STOPPED) && !next_is_wait; // R17
      next_wait_active = (next_state == lps_pkg::LPS_STOPPED) && next_is_wait;
      next_sys_on_pll = next_scm
                        || (next_ctrl.pll_select_bit && next_state == lps_pkg::LPS_RUN); // R2
      // Counters advance only on their own enabled clock, else freeze
      next_div_cnt = gate.sys ? div_cnt + CNT_W'(1) : div_cnt; // R5
      next_rti_cnt = gate.periodic_interrupt_timer ? rti_cnt + CNT_W'(1) : rti_cnt; // R5 R6
      next_wdog_cnt = gate.wdog ? wdog_cnt + CNT_W'(1) : wdog_cnt; // R5 R6
   end

   // Control registers; external reset restores every default at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= lps_pkg::LPS_CTRL_RESET; // R11
         state <= lps_pkg::LPS_RUN; // R11
         is_wait <= 1'b0;
         self_clock_mode <= 1'b0;
         qc_busy <= 1'b0;
         qc_cnt <= '0;
         gate <= lps_pkg::LPS_GATE_RESET;
         stop_active <= 1'b0;
         wait_active <= 1'b0;
         sys_on_pll <= 1'b0;
         clock_monitor_fail_reset <= 1'b0;
         alt_reset_vector <= 1'b0; // R11
         fail_q <= 1'b0;
         div_cnt <= '0;
         rti_cnt <= '0;
         wdog_cnt <= '0;
      end else begin
         ctrl <= next_ctrl;
         state <= next_state;
         is_wait <= next_is_wait;
         self_clock_mode <= next_scm;
         qc_busy <= next_qc_busy;
         qc_cnt <= next_qc_cnt;
         gate <= next_gate;
         stop_active <= next_stop_active;
         wait_active <= next_wait_active;
         sys_on_pll <= next_sys_on_pll;
         clock_monitor_fail_reset <= next_cm_reset;
         alt_reset_vector <= next_alt_vec;
         fail_q <= clock_fail;
         div_cnt <= next_div_cnt;
         rti_cnt <= next_rti_cnt;
         wdog_cnt <= next_wdog_cnt;
      end
   end

   // Read clears only what the reader saw, so a late set is kept
   always_comb begin
      rd_clr = '0;
      if (rd_en && paddr == lps_pkg::LPS_OFF_STATUS) begin
         rd_clr = prdata[lps_pkg::LPS_STAT_W-1:0];
      end
      next_mask = mask;
      if (wr_en && paddr == lps_pkg::LPS_OFF_MASK) begin
         next_mask = pwdata[lps_pkg::LPS_STAT_W-1:0];
      end
      next_status = (status & ~rd_clr) | evt;
      next_irq = |(next_status & next_mask);
   end

   // Interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= lps_pkg::LPS_STAT_RESET;
         mask <= lps_pkg::LPS_MASK_RESET;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         irq <= next_irq;
      end
   end

   // Checks on the sequencer and the self-clock handling
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_wait_scm_wake;
      asleep && is_wait && loss_evt && ctrl.self_clock_mode_enable
         && ctrl.self_clock_interrupt_enable
      |=> state == lps_pkg::LPS_RUN && self_clock_mode && qc_busy
         && status[lps_pkg::LPS_STAT_SCM_FLAG];
   endproperty
   a_wait_scm_wake: assert property (p_wait_scm_wake) else $error("wait self-clock wake failed"); // R1

   property p_scm_on_pll;
      self_clock_mode && state == lps_pkg::LPS_RUN |-> sys_on_pll && qc_busy;
   endproperty
   a_scm_on_pll: assert property (p_scm_on_pll) else $error("self-clock not on PLL"); // R2

   property p_full_stop_gates;
      stop_active && !ctrl.pseudo_stop_selection
      |-> !gate.osc && !gate.core && !gate.sys && !gate.periodic_interrupt_timer && !gate.wdog;
   endproperty
   a_full_stop_gates: assert property (p_full_stop_gates) else $error("clock alive in stop"); // R3 R4

   property p_freeze;
      stop_active ##1 stop_active |-> div_cnt == $past(div_cnt);
   endproperty
   a_freeze: assert property (p_freeze) else $error("divider moved in stop"); // R5

   property p_pseudo_timers;
      stop_active && ctrl.pseudo_stop_selection && ctrl.rti_pseudo_stop_enable
      ##1 stop_active |-> rti_cnt != $past(rti_cnt) && gate.periodic_interrupt_timer;
   endproperty
   a_pseudo_timers: assert property (p_pseudo_timers) else $error("timer halted"); // R6

   property p_voltage_regulator_req;
      $rose(stop_active) && !self_clock_mode |-> gate.voltage_regulator_lp;
   endproperty
   a_voltage_regulator_req: assert property (p_voltage_regulator_req) else $error("no regulator request"); // R7

   property p_stop_order;
      state == lps_pkg::LPS_RUN && stop_req && !ctrl.clock_monitor_enable && !self_clock_mode
      |=> !ctrl.pll_select_bit && gate.pll && gate.core
      ##1 !gate.pll && gate.core
      ##1 !gate.core && gate.sys && !stop_active
      ##1 !gate.sys && stop_active;
   endproperty
   a_stop_order: assert property (p_stop_order) else $error("stop gating order wrong"); // R8 R17

   property p_pseudo_scm;
      stop_active && ctrl.pseudo_stop_selection && self_clock_mode |-> gate.pll && !gate.voltage_regulator_lp;
   endproperty
   a_pseudo_scm: assert property (p_pseudo_scm) else $error("PLL or regulator dropped"); // R9

   property p_full_stop_abort;
      stop_active && !ctrl.pseudo_stop_selection && qc_busy |=> qc_cnt == '0;
   endproperty
   a_full_stop_abort: assert property (p_full_stop_abort) else $error("check not aborted"); // R10

   property p_cm_reset;
      loss_evt && !ctrl.self_clock_mode_enable
      |=> clock_monitor_fail_reset && alt_reset_vector && state == lps_pkg::LPS_RUN
      ##1 !clock_monitor_fail_reset;
   endproperty
   a_cm_reset: assert property (p_cm_reset) else $error("monitor reset missing"); // R12

   property p_pseudo_scm_wake;
      asleep && !is_wait && loss_evt && ctrl.self_clock_mode_enable
         && ctrl.self_clock_interrupt_enable
      |=> !stop_active && self_clock_mode && qc_busy;
   endproperty
   a_pseudo_scm_wake: assert property (p_pseudo_scm_wake) else $error("no self-clock wake"); // R13

   property p_no_wake;
      asleep && !is_wait && loss_evt && ctrl.self_clock_mode_enable
         && !ctrl.self_clock_interrupt_enable && !wake_irq
      |=> stop_active && status[lps_pkg::LPS_STAT_SCM_FLAG];
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("woke with interrupt off"); // R14

   property p_irq_wake;
      stop_active && wake_irq && !loss_evt |=> !stop_active && !ctrl.pll_select_bit
         && gate.osc && gate.sys;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("wake not on oscillator"); // R15

   property p_qc_good;
      qc_done && !loss_evt |=> !self_clock_mode && !qc_busy && status[lps_pkg::LPS_STAT_QC_OK];
   endproperty
   a_qc_good: assert property (p_qc_good) else $error("check end ignored"); // R16

   c_full_stop: cover property (state == lps_pkg::LPS_RUN && stop_req ##4 stop_active);
   c_pseudo_wake: cover property (stop_active && ctrl.pseudo_stop_selection ##1 !stop_active);
   c_scm_wake: cover property (asleep && loss_evt && ctrl.self_clock_interrupt_enable);
   c_qc_done: cover property (qc_done);

endmodule

`default_nettype wire

// ==== tb/lps_core_model.sv ====
// Processor core model that issues one-cycle stop and wait requests
`timescale 1ns/1ps
`default_nettype none
module lps_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go_stop,   // Bench asks for a stop
   input wire logic go_wait,   // Bench asks for a wait
   output logic stop_req,
   output logic wait_req
);
   // A held ask pulses the request every other cycle, each pulse one cycle long
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_req <= 1'b0;
         wait_req <= 1'b0;
      end else begin
         stop_req <= go_stop & ~stop_req;
         wait_req <= go_wait & ~wait_req;
      end
   end
endmodule
`default_nettype wire

// ==== tb/low_power_stop_clock_control_tb.sv ====
// Self-checking bench for the low-power stop clock control block
`timescale 1ns/1ps
`default_nettype none
module low_power_stop_clock_control_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic go_stop = 1'b0, go_wait = 1'b0, clock_fail = 1'b0, osc_tick = 1'b0, wake_irq = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, snap;
   logic pready, pslverr, err, stop_req, wait_req, stop_active, wait_active;
   logic self_clock_mode, sys_on_pll, qc_busy, cm_rst, alt_vec, irq;
   lps_pkg::lps_gate_t gate;
   int miscompares = 0, num_checks = 0, n;
   // Free-running 20 MHz clock
   always #25 pclk = ~pclk;
   lps_core_model lps_core_model_inst (.pclk(pclk), .presetn(presetn), .go_stop(go_stop),
      .go_wait(go_wait), .stop_req(stop_req), .wait_req(wait_req));
   // Short quality window keeps the run brief
   lps_stop_ctrl #(.QC_CYCLES(8)) lps_stop_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
      .wait_req(wait_req), .clock_fail(clock_fail), .osc_tick(osc_tick), .wake_irq(wake_irq),
      .gate(gate), .stop_active(stop_active), .wait_active(wait_active),
      .self_clock_mode(self_clock_mode), .sys_on_pll(sys_on_pll), .qc_busy(qc_busy),
      .clock_monitor_fail_reset(cm_rst), .alt_reset_vector(alt_vec), .irq(irq));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never reassigns psel in this step
      @(posedge pclk);
   endtask
   // Ask the core for stop or wait, then allow the four-step entry
   task automatic sleep(input logic is_stop);
      go_stop <= is_stop;
      go_wait <= ~is_stop;
      @(posedge pclk);
      go_stop <= 1'b0;
      go_wait <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   // Level change on an input, then let the block react
   task automatic lose(input logic v);
      clock_fail <= v;
      repeat (3) @(posedge pclk);
   endtask
   task automatic wake;
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic tick(input int cnt);
      repeat (cnt) begin
         osc_tick <= 1'b1;
         @(posedge pclk);
         osc_tick <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      #250000;
      miscompares++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(gate), 32'h0000_007E);
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      $display("test reset and refusal done");
      // Full stop from the PLL: everything off, select dropped, counters frozen
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0008);
      sleep(1'b1);
      chk(32'(gate), 32'h0000_0001);
      apb(1'b0, lps_pkg::LPS_OFF_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, lps_pkg::LPS_OFF_COUNT, 32'h0000_0000);
      snap = rd;
      repeat (10) @(posedge pclk);
      apb(1'b0, lps_pkg::LPS_OFF_COUNT, 32'h0000_0000);
      chk(rd, snap);
      wake();
      chk({30'h0, stop_active, sys_on_pll}, 32'h0000_0000);
      chk(32'(gate), 32'h0000_007E);
      $display("test full stop done");
      // Pseudo-stop keeps oscillator, timer and watchdog running
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0070);
      sleep(1'b1);
      chk(32'(gate), 32'h0000_0047);
      wake();
      $display("test pseudo-stop done");
      // Clock loss in wait: wake in self-clock, exact quality window
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0007);
      sleep(1'b0);
      chk(32'(wait_active), 32'h0000_0001);
      lose(1'b1);
      chk({28'h0, wait_active, self_clock_mode, sys_on_pll, qc_busy}, 32'h0000_0007);
      lose(1'b0);
      tick(7);
      chk(32'(self_clock_mode), 32'h0000_0001);
      tick(1);
      chk({30'h0, self_clock_mode, qc_busy}, 32'h0000_0000);
      apb(1'b0, lps_pkg::LPS_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0003, 32'h0000_0003);
      $display("test wait clock loss done");
      // Loss in pseudo-stop with interrupt off: stay asleep, flag and irq
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0013);
      sleep(1'b1);
      lose(1'b1);
      chk({29'h0, stop_active, gate.pll, irq}, 32'h0000_0006);
      apb(1'b1, lps_pkg::LPS_OFF_MASK, 32'h0000_0001);
      @(posedge pclk);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b0, lps_pkg::LPS_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      lose(1'b0);
      chk(32'(irq), 32'h0000_0000);
      // External reset in pseudo-stop restores defaults
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({29'h0, stop_active, self_clock_mode, alt_vec}, 32'h0000_0000);
      apb(1'b0, lps_pkg::LPS_OFF_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test silent loss and reset done");
      // Loss in pseudo-stop with interrupt on wakes into self-clock
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0017);
      sleep(1'b1);
      lose(1'b1);
      chk({30'h0, stop_active, self_clock_mode}, 32'h0000_0001);
      lose(1'b0);
      $display("test self-clock wake done");
      // Full stop in self-clock drops a half-done window, a whole one follows exit
      tick(5);
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0007);
      sleep(1'b1);
      tick(3);
      wake();
      tick(7);
      chk(32'(self_clock_mode), 32'h0000_0001);
      tick(1);
      chk(32'(self_clock_mode), 32'h0000_0000);
      $display("test stop in self-clock done");
      // Loss without self-clock gives the monitor reset
      apb(1'b1, lps_pkg::LPS_OFF_CTRL, 32'h0000_0011);
      sleep(1'b1);
      clock_fail <= 1'b1;
      n = 0;
      while (cm_rst !== 1'b1 && n < 5) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(cm_rst), 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk({30'h0, alt_vec, stop_active}, 32'h0000_0002);
      apb(1'b0, lps_pkg::LPS_OFF_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test monitor reset done");
      test_done();
   end
endmodule
`default_nettype wire
